// ===== core/front_panel_console.sv
// Purpose: Front panel console control: halt, manual access, interrupt,
//          sense and search functions for the processor card.
// Assumes: Processor status inputs are synchronous to clock.
// Notes:   Lamp multiplexing is outside this block.
`default_nettype none
// Summary of operation
// - Wait switch halts processor, console takes buses
// - Memory access key asserts access request
// - Load key copies switches to address
// - Drive address; show returned memory byte
// - Store key writes low switch byte
// - Up key increments, down key decrements address
// - Deposit on halt waits for stopped state
// - I/O port from switches 8 to 14
// - Output byte from switches 0 to 7
// - Store in I/O mode transfers, shows input
// - Interrupt key raises request, supplies switch byte
// - Reset injects restart zero, pulses reset out
// - Sense feeds switches 8-15 to inputs
// - Preset key loads pass counter, 1-256
// - Address match decrements pass counter
// - Zero count lights lamp, optional wait
// - Wait holds while switch set
// - Single step releases one machine cycle
// - Interrupt request cleared on interrupt cycle
module front_panel_console
  import console_pkg::*;
(
  input  wire logic                   clock,
  input  wire logic                   rst,
  input  wire logic [SwitchWidth-1:0] switchBank,
  input  wire logic                   waitSwitch,
  input  wire logic                   senseSwitch,
  input  wire logic                   searchWaitSwitch,
  input  wire logic                   memAccessKey,
  input  wire logic                   ioAccessKey,
  input  wire logic                   loadKey,
  input  wire logic                   store_key,
  input  wire logic                   addressUpKey,
  input  wire logic                   address_down_key,
  input  wire logic                   depositHaltKey,
  input  wire logic                   interruptKey,
  input  wire logic                   resetKey,
  input  wire logic                   countPresetKey,
  input  wire logic                   stepKey,
  input  wire logic                   ioInputSelect,
  input  wire logic                   haltAck,
  input  wire logic                   waitAck,
  input  wire logic                   interruptCycle,
  input  wire logic                   cycleStart,
  input  wire logic                   fetchCycle,
  input  wire logic                   cpuInputCycle,
  input  wire logic [AddrWidth-1:0]   cpuAddress,
  input  wire logic [DataWidth-1:0]   memReadData,
  input  wire logic [DataWidth-1:0]   ioReadData,
  output logic                        waitRequest,
  output logic                        busOwned,
  output logic                        accessRequest,
  output logic                        memAccessMode,
  output logic                        ioAccessMode,
  output logic [AddrWidth-1:0]        memAddress,
  output logic                        memWrite,
  output logic [DataWidth-1:0]        writeData,
  output logic [PortWidth-1:0]        ioPort,
  output logic                        ioWrite,
  output logic                        ioRead,
  output logic [DataWidth-1:0]        dataLamps,
  output logic                        interruptRequest,
  output logic [DataWidth-1:0]        injectData,
  output logic                        injectValid,
  output logic                        peripheralReset,
  output logic                        match_done_lamp
);
  localparam int NumKeys = 11;
  logic [NumKeys-1:0] keyRaw;
  logic [NumKeys-1:0] keyPress;
  logic [2:0]         swLevel;
  logic               pMem, pIo, pLoad, pStore, pUp, pDown;
  logic               pDepHalt, pIrq, pReset, pPreset, pStep;
  logic               waitOn, senseOn, searchWaitOn;
  logic [AddrWidth-1:0] addr_q;
  logic               depHaltPending_q;
  logic               resetInject_q;
  logic               searchDone;
  logic               searchHold_q;
  logic               stepping;
  step_t              step_q;

  assign keyRaw = {stepKey, countPresetKey, resetKey, interruptKey,
                   depositHaltKey, address_down_key, addressUpKey,
                   store_key, loadKey, ioAccessKey, memAccessKey};

  genvar k;
  generate
    for (k = 0; k < NumKeys; k++) begin : gKeys
      key_edge uKey (
        .clock (clock),
        .rst   (rst),
        .keyIn (keyRaw[k]),
        .level (),
        .press (keyPress[k])
      );
    end
    for (k = 0; k < 3; k++) begin : gSwitches
      key_edge uSw (
        .clock (clock),
        .rst   (rst),
        .keyIn (k == 0 ? waitSwitch :
                k == 1 ? senseSwitch : searchWaitSwitch),
        .level (swLevel[k]),
        .press ()
      );
    end
  endgenerate

  assign pMem         = keyPress[0];
  assign pIo          = keyPress[1];
  assign pLoad        = keyPress[2];
  assign pStore       = keyPress[3];
  assign pUp          = keyPress[4];
  assign pDown        = keyPress[5];
  assign pDepHalt     = keyPress[6];
  assign pIrq         = keyPress[7];
  assign pReset       = keyPress[8];
  assign pPreset      = keyPress[9];
  assign pStep        = keyPress[10];
  assign waitOn       = swLevel[0];
  assign senseOn      = swLevel[1];
  assign searchWaitOn = swLevel[2];

  pass_counter #(.Width(DataWidth)) uPass (
    .clock       (clock),
    .rst         (rst),
    .preset      (pPreset),
    .presetValue (switchBank[DataWidth-1:0]),
    .match       (fetchCycle && cycleStart && cpuAddress == addr_q),
    .done        (searchDone)
  );

  // Console address register.
  always_ff @(posedge clock) begin
    if (rst) begin
      addr_q <= AddrReset;
    end else if (pLoad) begin
      addr_q <= switchBank[AddrWidth-1:0];
    end else if (pUp) begin
      addr_q <= addr_q + AddrWidth'(1);
    end else if (pDown) begin
      addr_q <= addr_q - AddrWidth'(1);
    end
  end

  // Access mode selection; modes only live while waiting.
  always_ff @(posedge clock) begin
    if (rst || !waitOn) begin
      memAccessMode <= 1'b0;
      ioAccessMode  <= 1'b0;
      accessRequest <= 1'b0;
    end else if (pMem) begin
      memAccessMode <= 1'b1;
      ioAccessMode  <= 1'b0;
      accessRequest <= 1'b1;
    end else if (pIo) begin
      memAccessMode <= 1'b0;
      ioAccessMode  <= 1'b1;
      accessRequest <= 1'b1;
    end
  end

  // Search wait latch, held until a new preset or the switch drops.
  always_ff @(posedge clock) begin
    if (rst || pPreset || !searchWaitOn) begin
      searchHold_q <= 1'b0;
    end else if (searchDone) begin
      searchHold_q <= 1'b1;
    end
  end

  // Single step: release wait until the next machine cycle starts.
  always_ff @(posedge clock) begin
    if (rst) begin
      step_q <= StepIdle;
    end else begin
      unique case (step_q)
        StepIdle: if (pStep && waitRequest) step_q <= StepRun;
        StepRun:  if (cycleStart) step_q <= StepDone;
        StepDone: step_q <= StepIdle;
      endcase
    end
  end
  assign stepping = (step_q == StepRun);

  always_ff @(posedge clock) begin
    if (rst) begin
      waitRequest <= 1'b0;
      busOwned    <= 1'b0;
    end else begin
      waitRequest <= ((waitOn || searchHold_q) && !stepping)
                     || (step_q == StepDone);
      busOwned    <= waitOn && waitAck;
    end
  end

  // Deposit on halt.
  always_ff @(posedge clock) begin
    if (rst) begin
      depHaltPending_q <= 1'b0;
    end else if (pDepHalt) begin
      depHaltPending_q <= 1'b1;
    end else if (haltAck) begin
      depHaltPending_q <= 1'b0;
    end
  end

  // Manual memory and I/O strobes.
  always_ff @(posedge clock) begin
    if (rst) begin
      memAddress <= AddrReset;
      memWrite   <= 1'b0;
      writeData  <= '0;
      ioPort     <= '0;
      ioWrite    <= 1'b0;
      ioRead     <= 1'b0;
    end else begin
      memAddress <= addr_q;
      writeData  <= switchBank[DataWidth-1:0];
      ioPort     <= switchBank[PortLsb +: PortWidth];
      memWrite   <= (pStore && memAccessMode && busOwned)
                    || (depHaltPending_q && haltAck);
      ioWrite    <= pStore && ioAccessMode && busOwned
                    && !ioInputSelect;
      ioRead     <= pStore && ioAccessMode && busOwned
                    && ioInputSelect;
    end
  end

  // Data lamps show the returned byte.
  always_ff @(posedge clock) begin
    if (rst) begin
      dataLamps <= '0;
    end else if (ioAccessMode && ioRead) begin
      dataLamps <= ioReadData;
    end else if (memAccessMode) begin
      dataLamps <= memReadData;
    end
  end

  // Interrupt and reset injection; set wins over clear.
  always_ff @(posedge clock) begin
    if (rst) begin
      interruptRequest <= 1'b0;
      resetInject_q    <= 1'b0;
    end else if (pIrq || pReset) begin
      interruptRequest <= 1'b1;
      resetInject_q    <= pReset;
    end else if (interruptCycle) begin
      interruptRequest <= 1'b0;
    end
  end

  // Injected data: interrupt instruction or sense data.
  always_ff @(posedge clock) begin
    if (rst) begin
      injectData  <= '0;
      injectValid <= 1'b0;
    end else if (interruptCycle) begin
      injectData  <= resetInject_q ? RestartZero
                     : switchBank[DataWidth-1:0];
      injectValid <= 1'b1;
    end else if (senseOn && cpuInputCycle) begin
      injectData  <= switchBank[SenseLsb +: DataWidth];
      injectValid <= 1'b1;
    end else begin
      injectValid <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      peripheralReset <= 1'b0;
      match_done_lamp <= 1'b0;
    end else begin
      peripheralReset <= pReset;
      match_done_lamp <= searchDone;
    end
  end

  chk_wait_follows:
    assert property (@(posedge clock) disable iff (rst)
    (waitOn && step_q == StepIdle && $past(step_q) == StepIdle)
      |=> waitRequest)
    else $error("wait request dropped while switch set");
  chk_load_addr:
    assert property (@(posedge clock) disable iff (rst)
    pLoad |=> addr_q == $past(switchBank[AddrWidth-1:0]))
    else $error("load did not copy switches");
  chk_up_addr:
    assert property (@(posedge clock) disable iff (rst)
    (pUp && !pLoad) |=> addr_q == $past(addr_q) + 1'b1)
    else $error("address up failed");
  chk_irq_clear:
    assert property (@(posedge clock) disable iff (rst)
    (interruptCycle && !pIrq && !pReset) |=> !interruptRequest)
    else $error("interrupt request not cleared");
  chk_reset_inject:
    assert property (@(posedge clock) disable iff (rst)
    (interruptCycle && resetInject_q) |=> injectData == RestartZero
      && injectValid)
    else $error("restart instruction not injected");
  chk_io_port:
    assert property (@(posedge clock) disable iff (rst)
    ioWrite |-> ioPort == $past(switchBank[14:8]))
    else $error("port not from switches");
  sequence stepRelease;
    pStep && waitRequest ##1 step_q == StepRun;
  endsequence
  chk_step_release:
    assert property (@(posedge clock) disable iff (rst)
    stepRelease |=> !waitRequest)
    else $error("step did not release wait");
  chk_mem_store:
    assert property (@(posedge clock) disable iff (rst)
    (pStore && memAccessMode && busOwned) |=> memWrite
      && writeData == $past(switchBank[7:0]))
    else $error("store did not write memory");

  // A down press decrements the address register by one.
  chk_down_addr:
    assert property (@(posedge clock) disable iff (rst)
    (pDown && !pLoad && !pUp) |=> addr_q == $past(addr_q) - AddrWidth'(1))
    else $error("address down failed");
  chk_sense_data:
    assert property (@(posedge clock) disable iff (rst)
    (senseOn && cpuInputCycle && !interruptCycle) |=> injectValid
      && injectData == $past(switchBank[SenseLsb +: DataWidth]))
    else $error("sense data not injected");
  chk_dep_halt:
    assert property (@(posedge clock) disable iff (rst)
    (depHaltPending_q && haltAck) |=> memWrite
      && memAddress == $past(addr_q))
    else $error("deposit on halt did not write");
endmodule
`default_nettype wire

// ===== inc/console_pkg.sv
// Purpose: Shared constants for the front panel console controller.
// Assumes: 14-bit memory address, 8-bit data, 16 operator switches.
// Notes:   Opcode value is the restart-to-zero instruction.
`default_nettype none
package console_pkg;
  localparam int          AddrWidth    = 14;
  localparam int          SwitchWidth  = 16;
  localparam int          DataWidth    = 8;
  localparam int          PortLsb      = 8;
  localparam int          PortWidth    = 7;
  localparam int          SenseLsb     = 8;
  localparam int          SyncStages   = 2;
  localparam logic [7:0]  RestartZero  = 8'h05;
  localparam logic [13:0] AddrReset    = 14'h0000;
  localparam logic [7:0]  PassReset    = 8'h00;
  typedef enum logic [1:0] {StepIdle, StepRun, StepDone} step_t;
endpackage
`default_nettype wire

// ===== core/key_edge.sv
// Purpose: Synchronise one operator key and pulse once per press.
// Assumes: Key is a level, high while pressed.
// Notes:   First stage feeds only the second stage.
`default_nettype none
module key_edge (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic keyIn,
  output logic      level,
  output logic      press
);
  logic meta_q;
  logic sync_q;
  logic last_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
      press  <= 1'b0;
    end else begin
      meta_q <= keyIn;
      sync_q <= meta_q;
      last_q <= sync_q;
      press  <= sync_q & ~last_q;
    end
  end

  assign level = sync_q;

  chk_one_pulse:
    assert property (@(posedge clock) disable iff (rst)
    press |=> !press)
    else $error("key press pulse lasted more than one cycle");
endmodule
`default_nettype wire

// ===== core/pass_counter.sv
// Purpose: Pass counter for search operation.
// Assumes: Preset value 0 means 256 passes.
// Notes:   Done stays set until a new preset.
`default_nettype none
module pass_counter #(
  parameter int Width = 8
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             preset,
  input  wire logic [Width-1:0] presetValue,
  input  wire logic             match,
  output logic                  done
);
  logic [Width:0] count_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      count_q <= '0;
      done    <= 1'b0;
    end else if (preset) begin
      // Zero preset gives the full count of 2**Width passes.
      count_q <= (presetValue == '0) ? {1'b1, {Width{1'b0}}}
                                     : {1'b0, presetValue};
      done    <= 1'b0;
    end else if (match && count_q != '0) begin
      count_q <= count_q - {{Width{1'b0}}, 1'b1};
      if (count_q == {{Width{1'b0}}, 1'b1}) begin
        done <= 1'b1;
      end
    end
  end

  chk_done_on_last:
    assert property (@(posedge clock) disable iff (rst)
    (match && !preset && count_q == 1) |=> done)
    else $error("done not set on last pass");
endmodule
`default_nettype wire

// ===== test/cpu_card_model.sv
// Purpose: Processor card, memory and port model facing the console.
// Assumes: A machine cycle is four clocks; the program loops over 0-7.
// Notes:   slow delays the wait acknowledge to four clocks.
`default_nettype none
module cpu_card_model
  import console_pkg::*;
(
  input  wire logic                 clock,
  input  wire logic                 rst,
  input  wire logic                 slow,
  input  wire logic                 halted,
  input  wire logic                 waitRequest,
  input  wire logic                 interruptRequest,
  input  wire logic                 memWrite,
  input  wire logic [AddrWidth-1:0] memAddress,
  input  wire logic [DataWidth-1:0] writeData,
  input  wire logic [PortWidth-1:0] ioPort,
  output logic                      waitAck,
  output logic                      haltAck,
  output logic                      interruptCycle,
  output logic                      cycleStart,
  output logic                      fetchCycle,
  output logic                      cpuInputCycle,
  output logic [AddrWidth-1:0]      cpuAddress,
  output logic [DataWidth-1:0]      memReadData,
  output logic [DataWidth-1:0]      ioReadData
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [DataWidth-1:0] mem [2**AddrWidth];
  logic [2:0]           ackDly;
  logic [1:0]           phase;
  logic                 intSeen;
  initial for (int i = 0; i < 2**AddrWidth; i++) mem[i] = 8'(i) ^ 8'h5A;
  assign memReadData   = mem[memAddress];
  assign ioReadData    = {1'b0, ioPort} ^ 8'h3C;
  assign fetchCycle    = !waitAck;
  assign cpuInputCycle = cycleStart && cpuAddress == 14'h0005;
  always @(posedge clock) begin
    if (memWrite) mem[memAddress] <= writeData;
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      {ackDly, waitAck, haltAck, phase, cycleStart} <= '0;
      {interruptCycle, intSeen, cpuAddress} <= '0;
    end else begin
      ackDly <= {ackDly[1:0], waitRequest};
      waitAck <= slow ? ackDly[2] : waitRequest;
      haltAck <= halted;
      if (!waitAck) phase <= phase + 2'h1;
      cycleStart <= !waitAck && phase == 2'h3;
      if (cycleStart) cpuAddress <= (cpuAddress + 14'h1) & 14'h0007;
      interruptCycle <= interruptRequest && !waitAck && !intSeen
                        && !interruptCycle;
      intSeen <= interruptRequest && (intSeen || interruptCycle);
    end
  end
endmodule
`default_nettype wire

// ===== test/front_panel_console_tb.sv
// Purpose: Self-checking bench for the front panel console.
// Assumes: Keys are held three clocks, then released for eight.
// Notes:   A monitor pairs each result pulse with the oldest note.
`default_nettype none
module front_panel_console_tb
  import console_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int KMem = 0, KIo = 1, KLoad = 2, KStore = 3, KUp = 4;
  localparam int KDown = 5, KDep = 6, KInt = 7, KRst = 8, KPre = 9;
  localparam int KStep = 10;
  logic clock = 0, rst = 1, slow = 1, halted = 0, ioInputSelect = 0;
  logic waitSwitch = 0, senseSwitch = 0, searchWaitSwitch = 0;
  logic [10:0] keys = '0;
  logic [SwitchWidth-1:0] switchBank = '0;
  logic waitRequest, busOwned, accessRequest, memAccessMode, ioAccessMode;
  logic memWrite, ioWrite, ioRead, interruptRequest, injectValid;
  logic peripheralReset, match_done_lamp, waitAck, haltAck, interruptCycle;
  logic cycleStart, fetchCycle, cpuInputCycle;
  logic [AddrWidth-1:0] memAddress, cpuAddress;
  logic [DataWidth-1:0] writeData, dataLamps, injectData, memReadData;
  logic [DataWidth-1:0] ioReadData;
  logic [PortWidth-1:0] ioPort;
  logic [27:0] notes[$];
  logic [13:0] a;
  logic [7:0]  d;
  int failures = 0, tests_run = 0, starts = 0, hits = 0, acks = 0, n, m;
  always #12.5 clock = ~clock;
  front_panel_console front_panel_console_inst (.*,
    .memAccessKey(keys[KMem]), .ioAccessKey(keys[KIo]),
    .loadKey(keys[KLoad]), .store_key(keys[KStore]),
    .addressUpKey(keys[KUp]), .address_down_key(keys[KDown]),
    .depositHaltKey(keys[KDep]), .interruptKey(keys[KInt]),
    .resetKey(keys[KRst]), .countPresetKey(keys[KPre]),
    .stepKey(keys[KStep]));
  cpu_card_model cpu_card_model_inst (.*);
  task automatic check(input logic [27:0] seen, input logic [27:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    if (failures == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic take(input logic [27:0] seen);
    if (notes.size() == 0) check(seen, 28'h0);
    else check(seen, notes.pop_front());
  endtask
  task automatic press(input int k);
    @(posedge clock);
    keys[k] <= 1'b1;
    repeat (3) @(posedge clock);
    keys[k] <= 1'b0;
    repeat (8) @(posedge clock);
    @(negedge clock);
  endtask
  task automatic hold_bus();
    @(posedge clock) waitSwitch <= 1'b1;
    for (n = 0; n < 20 && busOwned !== 1'b1; n++) @(negedge clock);
  endtask
  always @(negedge clock) begin
    if (!rst && memWrite) take({4'h1, 2'b0, memAddress, writeData});
    if (!rst && ioWrite) take({4'h2, 9'h0, ioPort, writeData});
    if (!rst && ioRead) take({4'h3, 9'h0, ioPort, 8'h00});
    if (!rst && injectValid) take({4'h4, 16'h0, injectData});
    if (!rst && peripheralReset) take({4'h5, 24'h0});
    if (cycleStart) starts++;
    if (cycleStart && fetchCycle && cpuAddress == 14'h3) hits++;
    if (interruptCycle && interruptRequest) acks++;
  end
  initial begin
    #1500000;
    failures++;
    give_verdict();
  end
  initial begin
    void'($urandom(15));
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    check(28'({waitRequest, memAddress, match_done_lamp}), 28'h0);
    hold_bus();
    check(28'({waitRequest, busOwned}), 28'h3);
    press(KMem);
    check(28'({accessRequest, memAccessMode}), 28'h3);
    a = 14'($urandom);
    d = 8'($urandom);
    @(posedge clock) switchBank <= {2'b0, a};
    press(KLoad);
    check(28'(memAddress), 28'(a));
    check(28'(dataLamps), 28'(a[7:0] ^ 8'h5A));
    @(posedge clock) switchBank[7:0] <= d;
    notes.push_back({4'h1, 2'b0, a, d});
    press(KStore);
    check(28'(dataLamps), 28'(d));
    @(posedge clock) switchBank <= 16'h3FFF;
    press(KLoad);
    press(KUp);
    check(28'(memAddress), 28'h0);
    press(KDown);
    press(KDown);
    check(28'(memAddress), 28'h3FFE);
    check(28'(waitRequest), 28'h1);
    @(posedge clock) waitSwitch <= 1'b0;
    repeat (10) @(negedge clock);
    check(28'({waitRequest, memAccessMode}), 28'h0);
    @(posedge clock) slow <= 1'b0;
    hold_bus();
    press(KIo);
    check(28'(ioAccessMode), 28'h1);
    for (m = 0; m < 2; m++) begin
      @(posedge clock);
      switchBank <= 16'($urandom);
      ioInputSelect <= m[0];
      @(negedge clock);
      if (m == 1) notes.push_back({4'h3, 9'h0, switchBank[14:8], 8'h00});
      else notes.push_back({4'h2, 9'h0, switchBank[14:8], switchBank[7:0]});
      press(KStore);
    end
    check(28'(dataLamps), 28'({1'b0, switchBank[14:8]} ^ 8'h3C));
    m = starts;
    press(KStep);
    repeat (20) @(negedge clock);
    check(28'(starts - m), 28'h1);
    check(28'(waitRequest), 28'h1);
    d = 8'($urandom);
    @(posedge clock);
    waitSwitch <= 1'b0;
    switchBank <= {8'h00, d};
    press(KDep);
    repeat (10) @(negedge clock);
    notes.push_back({4'h1, 2'b0, 14'h3FFE, d});
    @(posedge clock) halted <= 1'b1;
    repeat (10) @(negedge clock);
    @(posedge clock) halted <= 1'b0;
    for (m = 0; m < 2; m++) begin
      d = 8'($urandom);
      n = acks;
      @(posedge clock) switchBank <= {8'h00, d};
      if (m == 1) notes.push_back({4'h5, 24'h0});
      notes.push_back({4'h4, 16'h0, (m == 1) ? RestartZero : d});
      press((m == 1) ? KRst : KInt);
      repeat (10) @(negedge clock);
      check(28'(acks - n), 28'h1);
      check(28'(interruptRequest), 28'h0);
    end
    d = 8'($urandom);
    @(posedge clock);
    switchBank <= {d, 8'h00};
    senseSwitch <= 1'b1;
    notes.push_back({4'h4, 16'h0, d});
    for (n = 0; n < 200 && notes.size() != 0; n++) @(negedge clock);
    @(posedge clock) senseSwitch <= 1'b0;
    for (m = 0; m < 2; m++) begin
      hold_bus();
      @(posedge clock);
      switchBank <= 16'h0003;
      searchWaitSwitch <= m[0];
      press(KLoad);
      @(posedge clock) switchBank <= {15'h0, m[0]};
      press(KPre);
      @(posedge clock) waitSwitch <= 1'b0;
      a = 14'(hits);
      for (n = 0; n < 9000 && match_done_lamp !== 1'b1; n++) @(negedge clock);
      check(28'(14'(hits) - a), (m == 1) ? 28'h1 : 28'h100);
      repeat (6) @(negedge clock);
      check(28'({match_done_lamp, waitRequest}), {27'h1, m[0]});
    end
    check(28'(notes.size()), 28'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
